// ===== hdl/slpc_params.svh
// Constants of the sleep mode controller.
// Function
// R01: Sleep entered only if arm bit set when sleep instruction executes.
// R02: Select 00 gives Idle: CPU and flash clocks halt, rest runs.
// R03: Select 01 or 11 gives Power-down: oscillator and all clocks stop.
// R04: Select 10 with crystal option gives Standby: Power-down, oscillator kept.
// R05: Standby wake-up resumes after six clock cycles.
// R06: Interrupt wake stalls CPU four cycles beyond start-up, then runs handler.
// R07: Register file and data memory kept unchanged across sleep.
// R08: Reset during sleep leaves sleep and restarts at reset vector.
// R09: Deep sleep wakes only on resets, start condition, level ext_interrupt_zero, pin change.
// R10: In deep sleep, edge-configured ext_interrupt_zero never wakes.
// R11: Power-down wake inserts delay chosen by clock-source fuses.
// R12: Idle wakes on any external or internal peripheral interrupt.
// R13: Comparator off in deep sleep unless using internal reference.
// R14: Enabled brown-out detector stays active in every sleep mode.
// R15: Enabled watchdog keeps running in all sleep modes.
// R16: Internal reference on only while brown-out or comparator needs it; code enables it with any enabled comparator.
// R17: Pin input buffers off when I/O clock stopped, except wake pins.
// R18: Control register: arm bit 5, select bits 6 and 4, bit 7 read-only.
// R19: Software sets arm bit just before sleep, clears it after wake.
// R20: With arm bit clear the sleep instruction is a no-operation.
`ifndef SLPC_PARAMS_SVH
`define SLPC_PARAMS_SVH
`define SLPC_ADDR_CTRL 2'h0
`define SLPC_ADDR_STATUS 2'h1
`define SLPC_CTRL_RESET 8'h00
`define SLPC_CTRL_WMASK 8'h7F
`define SLPC_BIT_PUD 7
`define SLPC_BIT_SEL_HI 6
`define SLPC_BIT_ARM 5
`define SLPC_BIT_SEL_LO 4
`define SLPC_BIT_ISC0_HI 1
`define SLPC_BIT_ISC0_LO 0
`define SLPC_STANDBY_CYCLES 4'h6
`define SLPC_INT_STALL_CYCLES 4'h4
`define SLPC_CNT_W 16
`endif

// ===== hdl/slpc_pkg.sv
// Types of the sleep mode controller.
package slpc_pkg;
    typedef enum logic [1:0] {
        SLPC_MODE_IDLE,
        SLPC_MODE_PDOWN,
        SLPC_MODE_STANDBY
    } slpc_mode_t;
    typedef enum logic [2:0] {
        SLPC_RUN,
        SLPC_SLEEP,
        SLPC_STARTUP,
        SLPC_STALL
    } slpc_state_t;
endpackage : slpc_pkg

// ===== hdl/slpc_delay.sv
// Down counter that times wake-up and stall delays.
`timescale 1ns/1ps
`include "slpc_params.svh"
module slpc_delay (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic load,
    input wire logic [`SLPC_CNT_W-1:0] load_value,
    output logic done
);
    typedef struct packed {
        logic [`SLPC_CNT_W-1:0] count;
        logic busy;
    } slpc_dly_st_t;
    slpc_dly_st_t st;
    slpc_dly_st_t next_st;
    always_comb begin
        next_st = st;
        if (load) begin
            next_st.count = load_value;
            next_st.busy = 1'b1;
        end else if (st.busy) begin
            if (st.count <= 16'h0001) begin
                next_st.busy = 1'b0;
                next_st.count = 16'h0000;
            end else begin
                next_st.count = st.count - 16'h0001;
            end
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    // Done is high during the last counted cycle, while count is one or less
    assign done = st.busy && st.count <= 16'h0001;
endmodule : slpc_delay

// ===== hdl/slpc_sleep_ctrl.sv
// Sleep mode controller: mode select, clock gating, wake-up sequencing.
`timescale 1ns/1ps
`include "slpc_params.svh"
module slpc_sleep_ctrl (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic sleep_instr,
    input wire logic crystal_option,
    input wire logic [`SLPC_CNT_W-1:0] clock_source_delay,
    input wire logic any_reset,
    input wire logic ext_interrupt_zero,
    input wire logic ext_interrupt_one,
    input wire logic pin_change_irq,
    input wire logic start_cond_irq,
    input wire logic nvm_ready_irq,
    input wire logic periph_irq,
    input wire logic brownout_fuse_enabled,
    input wire logic watchdog_enabled,
    input wire logic comparator_off_bit,
    input wire logic comparator_uses_ref,
    output logic cpu_clock_en,
    output logic flash_clock_en,
    output logic io_clock_en,
    output logic osc_en,
    output logic cpu_stall,
    output logic resume_at_reset_vector,
    output logic comparator_en,
    output logic vref_en,
    output logic brownout_en,
    output logic watchdog_run,
    output logic input_buf_en,
    output logic wake_pin_buf_en,
    output logic [1:0] sleep_mode
);
    ////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] ctrl;
        slpc_pkg::slpc_state_t state;
        slpc_pkg::slpc_mode_t mode;
        logic from_reset;
        logic [7:0] rdata;
        logic cpu_clk;
        logic flash_clk;
        logic io_clk;
        logic osc;
        logic stall;
        logic reset_vec;
        logic cmp_en;
        logic vref;
        logic brownout_detector;
        logic wdt;
        logic inbuf;
        logic wakebuf;
    } slpc_st_t;
    slpc_st_t st;
    slpc_st_t next_st;
    logic dly_load;
    logic [`SLPC_CNT_W-1:0] dly_value;
    logic dly_done;

    function automatic slpc_pkg::slpc_mode_t decode_mode(input logic [7:0] c, input logic xtal);
        logic [1:0] s;
        s = {c[`SLPC_BIT_SEL_HI], c[`SLPC_BIT_SEL_LO]};
        if (s == 2'b00) begin
            decode_mode = slpc_pkg::SLPC_MODE_IDLE; // [R02]
        end else if (s == 2'b10 && xtal) begin
            decode_mode = slpc_pkg::SLPC_MODE_STANDBY; // [R04]
        end else begin
            decode_mode = slpc_pkg::SLPC_MODE_PDOWN; // [R03]
        end
    endfunction : decode_mode

    function automatic logic deep(input slpc_pkg::slpc_mode_t m);
        deep = (m != slpc_pkg::SLPC_MODE_IDLE);
    endfunction : deep

    ////////////////////////////////////////////////////////////////
    slpc_delay u_delay (
        .clock(clock),
        .arst_n(arst_n),
        .load(dly_load),
        .load_value(dly_value),
        .done(dly_done)
    );

    // Level-sensed ext_interrupt_zero only when both sense bits are zero
    logic ext_interrupt_zero_level;
    logic wake_deep;
    logic wake_idle;
    logic wake_now;
    assign ext_interrupt_zero_level = !st.ctrl[`SLPC_BIT_ISC0_HI] && !st.ctrl[`SLPC_BIT_ISC0_LO];
    assign wake_deep = start_cond_irq || pin_change_irq || (ext_interrupt_zero && ext_interrupt_zero_level); // [R09] [R10]
    assign wake_idle = ext_interrupt_zero || ext_interrupt_one || pin_change_irq || start_cond_irq
        || nvm_ready_irq || periph_irq; // [R12]
    assign wake_now = deep(st.mode) ? wake_deep : wake_idle;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        dly_load = 1'b0;
        dly_value = '0;
        next_st.rdata = 8'h00;
        if (reg_write && reg_addr == `SLPC_ADDR_CTRL) begin
            next_st.ctrl = (reg_wdata & `SLPC_CTRL_WMASK) | (st.ctrl & ~`SLPC_CTRL_WMASK); // [R18]
        end
        if (reg_read) begin
            unique case (reg_addr)
                `SLPC_ADDR_CTRL: next_st.rdata = st.ctrl;
                `SLPC_ADDR_STATUS: next_st.rdata = {5'h00, st.state == slpc_pkg::SLPC_SLEEP,
                    st.mode};
                default: next_st.rdata = 8'h00;
            endcase
        end
        if (any_reset && st.state != slpc_pkg::SLPC_RUN) begin
            next_st.state = slpc_pkg::SLPC_RUN; // [R08]
            next_st.from_reset = 1'b1;
        end else begin
            unique case (st.state)
                slpc_pkg::SLPC_RUN: begin
                    next_st.from_reset = 1'b0;
                    if (sleep_instr && st.ctrl[`SLPC_BIT_ARM]) begin // [R01] [R20]
                        next_st.state = slpc_pkg::SLPC_SLEEP;
                        next_st.mode = decode_mode(st.ctrl, crystal_option);
                    end
                end
                slpc_pkg::SLPC_SLEEP: begin
                    if (wake_now) begin
                        dly_load = 1'b1;
                        if (st.mode == slpc_pkg::SLPC_MODE_PDOWN) begin
                            dly_value = clock_source_delay; // [R11]
                        end else if (st.mode == slpc_pkg::SLPC_MODE_STANDBY) begin
                            dly_value = {12'h000, `SLPC_STANDBY_CYCLES}; // [R05]
                        end else begin
                            dly_value = 16'h0001;
                        end
                        next_st.state = slpc_pkg::SLPC_STARTUP;
                    end
                end
                slpc_pkg::SLPC_STARTUP: begin
                    if (dly_done) begin
                        dly_load = 1'b1;
                        dly_value = {12'h000, `SLPC_INT_STALL_CYCLES}; // [R06]
                        next_st.state = slpc_pkg::SLPC_STALL;
                    end
                end
                slpc_pkg::SLPC_STALL: begin
                    if (dly_done) begin
                        next_st.state = slpc_pkg::SLPC_RUN;
                    end
                end
            endcase
        end
        // Clock and analog controls follow next state
        begin
            logic sleeping;
            logic dp;
            logic osc_needed;
            sleeping = (next_st.state == slpc_pkg::SLPC_SLEEP);
            dp = sleeping && deep(next_st.mode);
            osc_needed = (next_st.state == slpc_pkg::SLPC_SLEEP || next_st.state == slpc_pkg::SLPC_STARTUP)
                && next_st.mode == slpc_pkg::SLPC_MODE_PDOWN;
            // CPU halts only; memories keep content since no reset is issued
            next_st.cpu_clk = (next_st.state == slpc_pkg::SLPC_RUN); // [R07] [R02]
            next_st.flash_clk = !sleeping && next_st.state != slpc_pkg::SLPC_STARTUP;
            next_st.io_clk = !dp && !(next_st.state == slpc_pkg::SLPC_STARTUP && deep(next_st.mode)); // [R03]
            next_st.osc = !osc_needed; // [R04]
            next_st.stall = next_st.state != slpc_pkg::SLPC_RUN; // [R06]
            next_st.reset_vec = next_st.from_reset; // [R08]
            next_st.cmp_en = !comparator_off_bit && (!dp || comparator_uses_ref); // [R13]
            next_st.brownout_detector = brownout_fuse_enabled; // [R14]
            next_st.wdt = watchdog_enabled; // [R15]
            next_st.vref = brownout_fuse_enabled || next_st.cmp_en; // [R16]
            next_st.inbuf = next_st.io_clk; // [R17]
            next_st.wakebuf = 1'b1; // [R17]
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            st.ctrl <= `SLPC_CTRL_RESET;
            st.state <= slpc_pkg::SLPC_RUN;
            st.mode <= slpc_pkg::SLPC_MODE_IDLE;
            st.cpu_clk <= 1'b1;
            st.flash_clk <= 1'b1;
            st.io_clk <= 1'b1;
            st.osc <= 1'b1;
            st.inbuf <= 1'b1;
            st.wakebuf <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign cpu_clock_en = st.cpu_clk;
    assign flash_clock_en = st.flash_clk;
    assign io_clock_en = st.io_clk;
    assign osc_en = st.osc;
    assign cpu_stall = st.stall;
    assign resume_at_reset_vector = st.reset_vec;
    assign comparator_en = st.cmp_en;
    assign vref_en = st.vref;
    assign brownout_en = st.brownout_detector;
    assign watchdog_run = st.wdt;
    assign input_buf_en = st.inbuf;
    assign wake_pin_buf_en = st.wakebuf;
    assign sleep_mode = st.mode;

    ////////////////////////////////////////////////////////////////
    property p_no_arm_no_sleep;
        @(posedge clock) disable iff (!arst_n)
        (st.state == slpc_pkg::SLPC_RUN && sleep_instr && !st.ctrl[`SLPC_BIT_ARM] && !any_reset)
            |=> cpu_clock_en;
    endproperty
    a_no_arm_no_sleep: assert property (p_no_arm_no_sleep) else $error("sleep without arm bit"); // [R20]
    property p_enter;
        @(posedge clock) disable iff (!arst_n)
        (st.state == slpc_pkg::SLPC_RUN && sleep_instr && st.ctrl[`SLPC_BIT_ARM] && !any_reset)
            |=> !cpu_clock_en && !flash_clock_en;
    endproperty
    a_enter: assert property (p_enter) else $error("sleep not entered"); // [R01]
    property p_idle_io;
        @(posedge clock) disable iff (!arst_n)
        (st.state == slpc_pkg::SLPC_SLEEP && st.mode == slpc_pkg::SLPC_MODE_IDLE) |-> io_clock_en && osc_en;
    endproperty
    a_idle_io: assert property (p_idle_io) else $error("idle stopped io clock"); // [R02]
    property p_pdown;
        @(posedge clock) disable iff (!arst_n)
        (st.state == slpc_pkg::SLPC_SLEEP && st.mode == slpc_pkg::SLPC_MODE_PDOWN)
            |-> !osc_en && !io_clock_en && !input_buf_en;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down clocks running"); // [R03]
    property p_standby;
        @(posedge clock) disable iff (!arst_n)
        (st.state == slpc_pkg::SLPC_SLEEP && st.mode == slpc_pkg::SLPC_MODE_STANDBY) |-> osc_en && !io_clock_en;
    endproperty
    a_standby: assert property (p_standby) else $error("standby oscillator wrong"); // [R04]
    property p_standby_wake;
        @(posedge clock) disable iff (!arst_n || any_reset)
        (st.state == slpc_pkg::SLPC_SLEEP && st.mode == slpc_pkg::SLPC_MODE_STANDBY && wake_now)
            |-> ##1 (st.state == slpc_pkg::SLPC_STARTUP) [*6] ##1 st.state == slpc_pkg::SLPC_STALL;
    endproperty
    a_standby_wake: assert property (p_standby_wake) else $error("standby wake not six cycles"); // [R05]
    property p_stall4;
        @(posedge clock) disable iff (!arst_n || any_reset)
        $rose(st.state == slpc_pkg::SLPC_STALL) |-> cpu_stall [*4] ##1 !cpu_stall;
    endproperty
    a_stall4: assert property (p_stall4) else $error("stall not four cycles"); // [R06]
    property p_edge_ext_interrupt_zero;
        @(posedge clock) disable iff (!arst_n)
        (st.state == slpc_pkg::SLPC_SLEEP && deep(st.mode) && !ext_interrupt_zero_level && !pin_change_irq
            && !start_cond_irq && !any_reset) |=> st.state == slpc_pkg::SLPC_SLEEP;
    endproperty
    a_edge_ext_interrupt_zero: assert property (p_edge_ext_interrupt_zero) else $error("deep sleep woke wrongly"); // [R09] [R10]
    property p_reset_wake;
        @(posedge clock) disable iff (!arst_n)
        (any_reset && st.state != slpc_pkg::SLPC_RUN) |=> resume_at_reset_vector && cpu_clock_en;
    endproperty
    a_reset_wake: assert property (p_reset_wake) else $error("reset did not wake"); // [R08]
    property p_cmp;
        @(posedge clock) disable iff (!arst_n)
        (st.state == slpc_pkg::SLPC_SLEEP && deep(st.mode) && !comparator_uses_ref) |-> !comparator_en;
    endproperty
    a_cmp: assert property (p_cmp) else $error("comparator on in deep sleep"); // [R13]
    property p_wdt;
        @(posedge clock) disable iff (!arst_n)
        watchdog_enabled |=> watchdog_run;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog stopped"); // [R15]
    c_idle: cover property (@(posedge clock) st.state == slpc_pkg::SLPC_SLEEP && st.mode == slpc_pkg::SLPC_MODE_IDLE);
    c_pdown_wake: cover property (@(posedge clock)
        st.state == slpc_pkg::SLPC_STARTUP && st.mode == slpc_pkg::SLPC_MODE_PDOWN);
    c_standby: cover property (@(posedge clock) st.state == slpc_pkg::SLPC_SLEEP
        && st.mode == slpc_pkg::SLPC_MODE_STANDBY);
    c_reset: cover property (@(posedge clock) resume_at_reset_vector);
endmodule : slpc_sleep_ctrl

// ===== bench/slpc_cpu_model.sv
// Interrupt system model: holds requests until the core runs its handler.
`timescale 1ns/1ps
module slpc_cpu_model (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [5:0] raise,
    input wire logic cpu_clock_en,
    input wire logic cpu_stall,
    output logic [5:0] irq
);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 6'h00;
        end else if (cpu_clock_en && !cpu_stall) begin
            // Handler serviced only once the core runs again
            irq <= 6'h00;
        end else begin
            irq <= irq | raise;
        end
    end
endmodule : slpc_cpu_model

// ===== bench/tb_slpc_sleep_ctrl.sv
// Self-checking bench of the sleep mode controller.
`timescale 1ns/1ps
module tb_slpc_sleep_ctrl;
    logic clock, arst_n, reg_write, reg_read, sleep_instr, crystal_option, any_reset;
    logic brownout_fuse_enabled, watchdog_enabled, comparator_off_bit, comparator_uses_ref;
    logic cpu_clock_en, flash_clock_en, io_clock_en, osc_en, cpu_stall, resume_at_reset_vector;
    logic comparator_en, vref_en, brownout_en, watchdog_run, input_buf_en, wake_pin_buf_en;
    logic [1:0] sleep_mode;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [15:0] clock_source_delay;
    logic [5:0] raise, irq;
    int num_errors, n_tests;

    slpc_sleep_ctrl slpc_sleep_ctrl_inst (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .sleep_instr(sleep_instr), .crystal_option(crystal_option), .clock_source_delay(clock_source_delay),
        .any_reset(any_reset), .ext_interrupt_zero(irq[0]), .ext_interrupt_one(irq[1]),
        .pin_change_irq(irq[2]), .start_cond_irq(irq[3]), .nvm_ready_irq(irq[4]), .periph_irq(irq[5]),
        .brownout_fuse_enabled(brownout_fuse_enabled), .watchdog_enabled(watchdog_enabled),
        .comparator_off_bit(comparator_off_bit), .comparator_uses_ref(comparator_uses_ref),
        .cpu_clock_en(cpu_clock_en), .flash_clock_en(flash_clock_en), .io_clock_en(io_clock_en),
        .osc_en(osc_en), .cpu_stall(cpu_stall), .resume_at_reset_vector(resume_at_reset_vector),
        .comparator_en(comparator_en), .vref_en(vref_en), .brownout_en(brownout_en),
        .watchdog_run(watchdog_run), .input_buf_en(input_buf_en), .wake_pin_buf_en(wake_pin_buf_en),
        .sleep_mode(sleep_mode));

    slpc_cpu_model slpc_cpu_model_inst (.clock(clock), .arst_n(arst_n), .raise(raise),
        .cpu_clock_en(cpu_clock_en), .cpu_stall(cpu_stall), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] vec();
        return {cpu_clock_en, flash_clock_en, io_clock_en, osc_en, input_buf_en, comparator_en,
            brownout_en, watchdog_run};
    endfunction : vec

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic sleep_go(input logic [7:0] ctrl);
        wr(2'h0, ctrl);
        @(posedge clock);
        sleep_instr <= 1'b1;
        @(posedge clock);
        sleep_instr <= 1'b0;
        #1;
    endtask : sleep_go

    task automatic poke(input logic [5:0] src);
        @(posedge clock);
        raise <= src;
        @(posedge clock);
        raise <= 6'h00;
    endtask : poke

    // Counts edges from the wake edge until the core clock returns
    task automatic wake(input logic [5:0] src, input logic [7:0] exp_n);
        int n;
        n = -1;
        poke(src);
        while (n < 200 && cpu_clock_en !== 1'b1) begin
            @(posedge clock);
            #1;
            n = n + 1;
        end
        chk(8'(n), exp_n);
    endtask : wake

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial begin
        #300000;
        num_errors = num_errors + 1;
        end_sim();
    end

    initial begin
        {arst_n, reg_write, reg_read, sleep_instr, crystal_option, any_reset} = 6'h00;
        {comparator_off_bit, comparator_uses_ref, reg_addr, reg_wdata, raise} = 18'h0_0000;
        {brownout_fuse_enabled, watchdog_enabled} = 2'h3;
        clock_source_delay = 16'h0003;
        num_errors = 0;
        n_tests = 0;
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        rd(2'h0, 8'h00);
        wr(2'h0, 8'hFF);
        rd(2'h0, 8'h7F);
        rd(2'h3, 8'h00);
        sleep_go(8'h40);
        chk(vec(), 8'hFF);
        for (int i = 0; i < 6; i++) begin
            sleep_go(8'h20);
            chk(vec(), 8'h3F);
            wake(6'(1 << i), 8'h05);
        end
        rd(2'h0, 8'h20);
        wr(2'h0, 8'h00);
        crystal_option <= 1'b1;
        sleep_go(8'h61);
        chk(vec(), 8'h13);
        chk({5'h00, wake_pin_buf_en, sleep_mode}, 8'h06);
        poke(6'h01);
        repeat (20) @(posedge clock);
        chk(vec(), 8'h13);
        poke(6'h32);
        repeat (20) @(posedge clock);
        chk(vec(), 8'h13);
        wake(6'h04, 8'h0A);
        rd(2'h1, 8'h02);
        crystal_option <= 1'b0;
        sleep_go(8'h60);
        chk(vec(), 8'h03);
        wake(6'h08, 8'h07);
        sleep_go(8'h30);
        chk(vec(), 8'h03);
        wake(6'h01, 8'h07);
        sleep_go(8'h70);
        chk(vec(), 8'h03);
        @(posedge clock);
        any_reset <= 1'b1;
        @(posedge clock);
        #1;
        chk({5'h00, cpu_clock_en, cpu_stall, resume_at_reset_vector}, 8'h05);
        @(posedge clock);
        any_reset <= 1'b0;
        {brownout_fuse_enabled, watchdog_enabled, comparator_off_bit} <= 3'h1;
        repeat (3) @(posedge clock);
        #1;
        chk({vref_en, brownout_en, watchdog_run}, 8'h00);
        @(posedge clock);
        {comparator_off_bit, comparator_uses_ref} <= 2'h1;
        sleep_go(8'h30);
        chk({7'h00, vref_en}, 8'h01);
        wake(6'h04, 8'h07);
        end_sim();
    end
endmodule : tb_slpc_sleep_ctrl
